// File: i2c_pkg.sv
// Constants, field layouts and types for the I2C master register port
// Function
// R1 - Bits 7:1 of the target address register hold the 7-bit slave address sent on the bus.
// R2 - That address only selects the slave on the bus and never names a location inside it.
// R3 - Bit 0 of the target address register picks a read when one and a write when zero.
// R4 - The read-only receive byte register is loaded by hardware with every received byte.
// R5 - The write-only transmit byte register holds the next address or data byte to send.
// R6 - The slave's internal location goes out through the transmit register before any data.
// R7 - Software sees exactly four byte registers: control/status, transmit, receive, address.
// R8 - The transmit-empty flag is set once the transmit byte has been sent to the slave.
// R9 - Writing a new byte into the transmit register clears the transmit-empty flag.
// R10 - A write to the interrupt vector register clears the pending transmit interrupt only; the code clears the pending receive interrupt too.
// R11 - The receive interrupt enable lets the receive-full condition raise an interrupt.
// R12 - A read first writes the location, then a repeated start with the read bit, then receives.
package i2c_pkg;

  // Register map, byte addresses in the microcontroller data space
  localparam logic [15:0] CTL_ADDR = 16'hFFC0;
  localparam logic [15:0] TX_ADDR  = 16'hFFC1;
  localparam logic [15:0] RX_ADDR  = 16'hFFC2;
  localparam logic [15:0] ADR_ADDR = 16'hFFC3;
  localparam logic [7:0]  REG_RST  = 8'h00;

  // Field positions of the target address register
  localparam int RW_BIT   = 0;
  localparam int ADR_LSB  = 1;
  localparam int ADR_MSB  = 7;

  // Bit sequencing: eight data bits then the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // SCL quarter periods; the bit engine runs four quarters per SCL cycle
  localparam int CLK_PERIOD_NS = 100;
  localparam int STD_QTR_NS    = 2500;
  localparam int FAST_QTR_NS   = 625;
  localparam logic [7:0] QTR_STD  = 8'(STD_QTR_NS / CLK_PERIOD_NS);
  localparam logic [7:0] QTR_FAST = 8'(FAST_QTR_NS / CLK_PERIOD_NS);

  // Control and status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic rxf;
    logic receive_interrupt_enable;
    logic err;
    logic frq;
    logic transmit_empty_flag;
    logic txie;
    logic stprd;
    logic stpwr;
  } ctl_t;

  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_START  = 6'h02,
    S_BYTE   = 6'h04,
    S_HOLD   = 6'h08,
    S_RSTART = 6'h10,
    S_STOP   = 6'h20
  } state_t;

  typedef enum logic [1:0] {
    ST_ADDRW = 2'h0,
    ST_DATA  = 2'h1,
    ST_ADDRR = 2'h2,
    ST_READ  = 2'h3
  } stage_t;

endpackage : i2c_pkg

// File: i2c_master_register_port.sv
// I2C master with its four memory-mapped byte registers
`timescale 1ns/1ps
`default_nettype none

module i2c_master_register_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [15:0] addr,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [7:0]  wdata,
  input  wire logic        ivec_wr,
  output logic      [7:0]  rdata,
  output logic             rx_int_req,
  output logic             tx_int_req,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  i2c_pkg::state_t state_q, state_d;
  i2c_pkg::stage_t stage_q, stage_d;
  i2c_pkg::ctl_t   ctl_q;
  logic [1:0]      ph_q, ph_d;
  logic [7:0]      div_q, div_d;
  logic [3:0]      bit_q, bit_d;
  logic [7:0]      shift_q, shift_d;
  logic [7:0]      rx_q, tx_q, adr_q, rdata_q;
  logic            ack_q, ack_d;
  logic            tx_full_q, tx_pend_q, rx_pend_q;
  logic            scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic            scl_oe_q, sda_oe_q;
  logic            txe_set, rxf_set, err_set, tx_take;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode; four byte registers and nothing else answers
  // R7 four byte registers
  wire wr_ctl = wr && (addr == i2c_pkg::CTL_ADDR);
  wire wr_tx  = wr && (addr == i2c_pkg::TX_ADDR);
  wire wr_adr = wr && (addr == i2c_pkg::ADR_ADDR);
  wire rd_rx  = rd && (addr == i2c_pkg::RX_ADDR);
  wire [7:0] rd_mux = (addr == i2c_pkg::CTL_ADDR) ? ctl_q :
                      (addr == i2c_pkg::RX_ADDR)  ? rx_q  :
                      (addr == i2c_pkg::ADR_ADDR) ? adr_q : i2c_pkg::REG_RST;

  // Bit timing: quarter ticks, phase 1 waits for SCL to really rise (stretching)
  wire [7:0] qtr       = ctl_q.frq ? i2c_pkg::QTR_FAST : i2c_pkg::QTR_STD;
  wire       tick      = (div_q == 8'(qtr - 8'h01));
  wire       adv       = tick && ((ph_q != 2'h1) || scl_s_q);
  wire       phase_end = adv && (ph_q == 2'h3);
  wire       quiet     = (state_q == i2c_pkg::S_IDLE) || (state_q == i2c_pkg::S_HOLD);
  wire       rx_mode   = (stage_q == i2c_pkg::ST_READ);
  wire       ack_slot  = (bit_q == i2c_pkg::ACK_SLOT);

  // Pin drive levels per state and phase; open drain so only pull-low is driven
  wire byte_sda_low = rx_mode ? (ack_slot && !ctl_q.stprd) : (!ack_slot && !shift_q[7]);
  wire scl_low_w = (state_q == i2c_pkg::S_HOLD) ||
                   ((state_q == i2c_pkg::S_BYTE) && (ph_q == 2'h0 || ph_q == 2'h3)) ||
                   ((state_q == i2c_pkg::S_RSTART) && (ph_q == 2'h0)) ||
                   ((state_q == i2c_pkg::S_START || state_q == i2c_pkg::S_RSTART) &&
                    (ph_q == 2'h3)) ||
                   ((state_q == i2c_pkg::S_STOP) && (ph_q == 2'h0));
  wire sda_low_w = ((state_q == i2c_pkg::S_BYTE) && byte_sda_low) ||
                   ((state_q == i2c_pkg::S_START || state_q == i2c_pkg::S_RSTART) &&
                    ph_q[1]) ||
                   ((state_q == i2c_pkg::S_STOP) && (ph_q != 2'h3));

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe     = scl_oe_q;
  assign sda_oe     = sda_oe_q;
  assign rdata      = rdata_q;
  // R11 receive interrupt gate
  assign rx_int_req = ctl_q.receive_interrupt_enable && rx_pend_q;
  assign tx_int_req = ctl_q.txie && tx_pend_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_comb begin
    state_d = state_q;
    stage_d = stage_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ack_d   = ack_q;
    ph_d    = adv ? 2'(ph_q + 2'h1) : ph_q;
    div_d   = (quiet || tick) ? 8'h00 : 8'(div_q + 8'h01);
    txe_set = 1'b0;
    rxf_set = 1'b0;
    err_set = 1'b0;
    tx_take = 1'b0;
    if (quiet) begin
      ph_d = 2'h0;
    end
    unique case (state_q)
      i2c_pkg::S_IDLE: begin
        if (tx_full_q) begin
          // R12 location written first
          // R1 address byte with write bit
          state_d = i2c_pkg::S_START;
          stage_d = i2c_pkg::ST_ADDRW;
          shift_d = {adr_q[i2c_pkg::ADR_MSB:i2c_pkg::ADR_LSB], 1'b0};
        end
      end
      i2c_pkg::S_START, i2c_pkg::S_RSTART: begin
        if (phase_end) begin
          state_d = i2c_pkg::S_BYTE;
          bit_d   = 4'h0;
        end
      end
      i2c_pkg::S_BYTE: begin
        // Receive samples at the end of high phase 2; transmit shifts only with SCL low so SDA never
        // moves under a high clock, which a slave would take for a start or stop
        if (adv && ph_q == 2'h2) begin
          if (ack_slot) begin
            ack_d = sda_s_q;
          end else if (rx_mode) begin
            shift_d = {shift_q[6:0], sda_s_q};
          end
        end
        if (phase_end && !ack_slot) begin
          bit_d = 4'(bit_q + 4'h1);
          if (!rx_mode) begin
            shift_d = {shift_q[6:0], 1'b0};
          end
        end else if (phase_end) begin
          bit_d = 4'h0;
          if (rx_mode) begin
            // R4 byte lands in receive register
            rxf_set = 1'b1;
            state_d = ctl_q.stprd ? i2c_pkg::S_STOP : i2c_pkg::S_HOLD;
          end else if (ack_q) begin
            // A refused address drops the pending byte; else idle would retry forever
            err_set = 1'b1;
            tx_take = (stage_q == i2c_pkg::ST_ADDRW);
            state_d = i2c_pkg::S_STOP;
          end else begin
            unique case (stage_q)
              i2c_pkg::ST_ADDRW: begin
                // R6 location byte follows address
                shift_d = tx_q;
                tx_take = 1'b1;
                stage_d = i2c_pkg::ST_DATA;
              end
              i2c_pkg::ST_DATA: begin
                // R8 transmit byte sent
                txe_set = 1'b1;
                // R3 read bit turns the transfer round
                if (adr_q[i2c_pkg::RW_BIT]) begin
                  // R12 repeated start with read bit
                  state_d = i2c_pkg::S_RSTART;
                  stage_d = i2c_pkg::ST_ADDRR;
                  shift_d = {adr_q[i2c_pkg::ADR_MSB:i2c_pkg::ADR_LSB], 1'b1};
                end else begin
                  state_d = ctl_q.stpwr ? i2c_pkg::S_STOP : i2c_pkg::S_HOLD;
                end
              end
              i2c_pkg::ST_ADDRR: begin
                stage_d = i2c_pkg::ST_READ;
              end
              i2c_pkg::ST_READ: begin
                stage_d = i2c_pkg::ST_READ;
              end
            endcase
          end
        end
      end
      i2c_pkg::S_HOLD: begin
        // SCL held low until software has served the previous byte
        if (rx_mode) begin
          if (!ctl_q.rxf) begin
            state_d = i2c_pkg::S_BYTE;
          end
        end else if (tx_full_q) begin
          shift_d = tx_q;
          tx_take = 1'b1;
          state_d = i2c_pkg::S_BYTE;
        end else if (ctl_q.stpwr) begin
          state_d = i2c_pkg::S_STOP;
        end
      end
      i2c_pkg::S_STOP: begin
        if (phase_end) begin
          state_d = i2c_pkg::S_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only the second stages
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else if (ce) begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // Sequencer registers and registered pin enables
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= i2c_pkg::S_IDLE;
      stage_q  <= i2c_pkg::ST_ADDRW;
      ph_q     <= 2'h0;
      div_q    <= 8'h00;
      bit_q    <= 4'h0;
      shift_q  <= i2c_pkg::REG_RST;
      ack_q    <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      state_q  <= state_d;
      stage_q  <= stage_d;
      ph_q     <= ph_d;
      div_q    <= div_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      ack_q    <= ack_d;
      scl_oe_q <= scl_low_w;
      sda_oe_q <= sda_low_w;
    end
  end

  // Software-written registers plus hardware-loaded receive byte and read data; the address is a bus identity only
  // R2 address kept as bus identity
  always_ff @(posedge clk) begin
    if (srst) begin
      adr_q   <= i2c_pkg::REG_RST;
      tx_q    <= i2c_pkg::REG_RST;
      rx_q    <= i2c_pkg::REG_RST;
      rdata_q <= i2c_pkg::REG_RST;
    end else if (ce) begin
      if (wr_adr) adr_q <= wdata;
      // R5 transmit register loaded
      if (wr_tx) tx_q <= wdata;
      if (rxf_set) rx_q <= shift_q;
      if (rd) rdata_q <= rd_mux;
    end
  end

  // Status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q     <= '0;
      tx_full_q <= 1'b0;
      tx_pend_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctl) begin
        ctl_q.receive_interrupt_enable  <= wdata[6];
        ctl_q.frq   <= wdata[4];
        ctl_q.txie  <= wdata[2];
        ctl_q.stprd <= wdata[1];
        ctl_q.stpwr <= wdata[0];
      end
      ctl_q.err <= err_set || (wr_ctl ? wdata[5] : ctl_q.err);
      ctl_q.rxf <= rxf_set || (ctl_q.rxf && !rd_rx);
      // R9 new byte clears transmit-empty
      ctl_q.transmit_empty_flag <= txe_set || (ctl_q.transmit_empty_flag && !wr_tx);
      tx_full_q <= wr_tx || (tx_full_q && !tx_take);
      // R10 vector write clears both transmit and receive pending
      tx_pend_q <= txe_set || (tx_pend_q && !ivec_wr);
      rx_pend_q <= rxf_set || (rx_pend_q && !ivec_wr);
    end
  end

endmodule : i2c_master_register_port

`default_nettype wire

// File: i2c_port_sva.sv
// Port-level assertions for the I2C master register port
`timescale 1ns/1ps
`default_nettype none
module i2c_port_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic [15:0] addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        ivec_wr,
  input wire logic [7:0]  rdata,
  input wire logic        rx_int_req,
  input wire logic        tx_int_req,
  input wire logic        scl_oe,
  input wire logic        sda_oe
);
  // Decodes of the register strobes
  wire logic ctl_rd = ce && rd && !wr && addr == i2c_pkg::CTL_ADDR;
  wire logic mapped = addr[15:2] == 14'h3FF0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////
  reset_clear_a: assert property (
    disable iff (1'b0) srst && ce |=> rdata == 8'h00 && !scl_oe && !sda_oe
    && !rx_int_req && !tx_int_req) else $error("reset left outputs set");
  unmapped_rd_a: assert property (
    ce && rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
  tx_rd_zero_a: assert property (
    ce && rd && addr == i2c_pkg::TX_ADDR |=> rdata == 8'h00) else $error("tx byte readable");
  rdata_hold_a: assert property (
    !(ce && rd) |=> $stable(rdata)) else $error("read data moved");
  ivec_clear_a: assert property (
    ce && ivec_wr |=> !tx_int_req && !rx_int_req) else $error("pending not cleared");
  rx_gate_a: assert property (
    ctl_rd |=> rdata[6] || !rx_int_req) else $error("rx interrupt while disabled");
  txe_clear_a: assert property (
    ce && wr && addr == i2c_pkg::TX_ADDR ##2 ctl_rd |=> !rdata[3]) else $error("txe kept");
  // A start pulls data with the clock released; the clock must follow
  start_clk_a: assert property (
    $rose(sda_oe) && !scl_oe |-> ##[1:60] scl_oe) else $error("start without clock");
endmodule : i2c_port_checker
bind i2c_master_register_port i2c_port_checker chk_inst (
  .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wr(wr), .rd(rd), .ivec_wr(ivec_wr),
  .rdata(rdata), .rx_int_req(rx_int_req), .tx_int_req(tx_int_req),
  .scl_oe(scl_oe), .sda_oe(sda_oe)
);
`default_nettype wire

// File: i2c_slave_model.sv
// Behavioural I2C slave: acks its own address, logs writes, answers reads
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] SLV_ADR = 7'h50,
  parameter logic [7:0] RD_BYTE = 8'hA5
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      pull
);
  int         bitn = 0;
  int         starts = 0;
  logic [7:0] sh = 8'h00;
  logic [7:0] adr_b = 8'h00;
  logic [7:0] dat_b = 8'h00;
  logic       rdm = 1'b0;
  logic       first = 1'b0;
  initial pull = 1'b0;
  // Start or repeated start restarts framing with an address byte
  always @(negedge sda) begin
    if (scl) begin
      bitn = 0;
      first = 1'b1;
      rdm = 1'b0;
      starts++;
    end
  end
  // Sample with the clock high; a master NACK ends the read
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8 && rdm && sda) rdm = 1'b0;
    bitn++;
  end
  // Change SDA only with the clock low, so no false start or stop
  always @(negedge scl) begin
    if (bitn == 8 && first) begin
      adr_b = sh;
      first = 1'b0;
      rdm = sh[0] && sh[7:1] == SLV_ADR;
      pull = sh[7:1] == SLV_ADR;
    end else if (bitn == 8) begin
      // Only the addressed slave takes and acknowledges data bytes
      if (!rdm && adr_b[7:1] == SLV_ADR) dat_b = sh;
      pull = !rdm && adr_b[7:1] == SLV_ADR;
    end else if (bitn == 9) begin
      bitn = 0;
      pull = rdm && !RD_BYTE[7];
    end else begin
      pull = rdm && !RD_BYTE[7 - bitn];
    end
  end
endmodule : i2c_slave_model
`default_nettype wire

// File: i2c_master_register_port_tb.sv
// Self-checking bench for the I2C master register port
`timescale 1ns/1ps
`default_nettype none
module i2c_master_register_port_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        ivec_wr = 1'b0;
  logic [7:0]  rdata;
  logic        rx_int_req, tx_int_req, scl_o, scl_oe, sda_o, sda_oe, pull;
  // Open-drain lines with pull-ups
  wire logic   scl_i = !scl_oe;
  wire logic   sda_i = !(sda_oe || pull);
  int          fails = 0;
  int          checks = 0;
  i2c_master_register_port i_i2c_master_register_port (
    .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .ivec_wr(ivec_wr), .rdata(rdata), .rx_int_req(rx_int_req), .tx_int_req(tx_int_req),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  i2c_slave_model i_i2c_slave_model (.scl(scl_i), .sda(sda_i), .pull(pull));
  initial begin
    forever #50 clk = !clk;
  end
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One register cycle; read data is registered, valid on return
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk);
    #1 {wr, rd} = 2'b00;
  endtask : cyc
  // Interrupt vector write: a one-cycle strobe
  task automatic pulse_ivec();
    @(posedge clk);
    #1 ivec_wr = 1'b1;
    @(posedge clk);
    #1 ivec_wr = 1'b0;
  endtask : pulse_ivec
  task automatic ctl_wait(input int b);
    int n;
    n = 0;
    do begin
      cyc(1'b0, i2c_pkg::CTL_ADDR, 8'h00);
      n++;
    end while (rdata[b] !== 1'b1 && n < 2000);
  endtask : ctl_wait
  // Bus counts as idle once both lines stay released for a while
  task automatic idle();
    int q;
    q = 0;
    for (int n = 0; n < 4000 && q < 120; n++) begin
      @(posedge clk);
      q = (scl_oe || sda_oe) ? 0 : q + 1;
    end
  endtask : idle
  task automatic t_reset();
    for (int a = 0; a < 5; a++) begin
      cyc(1'b0, i2c_pkg::CTL_ADDR + 16'(a), 8'h00);
      chk(rdata, i2c_pkg::REG_RST);
    end
    chk({6'h00, scl_o, sda_o}, 8'h00);
  endtask : t_reset
  task automatic t_write();
    cyc(1'b1, i2c_pkg::ADR_ADDR, 8'hA0);
    cyc(1'b0, i2c_pkg::ADR_ADDR, 8'h00);
    chk(rdata, 8'hA0);
    cyc(1'b1, i2c_pkg::CTL_ADDR, 8'h15);
    cyc(1'b1, i2c_pkg::TX_ADDR, 8'h3C);
    cyc(1'b0, i2c_pkg::CTL_ADDR, 8'h00);
    chk(rdata & 8'h08, 8'h00);
    ctl_wait(3);
    chk({7'h00, tx_int_req}, 8'h01);
    chk(i_i2c_slave_model.adr_b, 8'hA0);
    chk(i_i2c_slave_model.dat_b, 8'h3C);
    pulse_ivec();
    chk({7'h00, tx_int_req}, 8'h00);
    cyc(1'b0, i2c_pkg::CTL_ADDR, 8'h00);
    chk(rdata & 8'h08, 8'h08);
    idle();
  endtask : t_write
  // Unknown address gets no ack: error set, then cleared by software
  task automatic t_nack();
    cyc(1'b1, i2c_pkg::ADR_ADDR, 8'h62);
    cyc(1'b1, i2c_pkg::CTL_ADDR, 8'h01);
    cyc(1'b1, i2c_pkg::TX_ADDR, 8'h11);
    ctl_wait(5);
    chk(rdata & 8'h20, 8'h20);
    idle();
    cyc(1'b1, i2c_pkg::CTL_ADDR, 8'h00);
    cyc(1'b0, i2c_pkg::CTL_ADDR, 8'h00);
    chk(rdata & 8'h20, 8'h00);
  endtask : t_nack
  task automatic t_read();
    cyc(1'b1, i2c_pkg::ADR_ADDR, 8'hA1);
    cyc(1'b1, i2c_pkg::CTL_ADDR, 8'h52);
    cyc(1'b1, i2c_pkg::TX_ADDR, 8'h07);
    ctl_wait(7);
    chk({7'h00, rx_int_req}, 8'h01);
    chk(i_i2c_slave_model.dat_b, 8'h07);
    chk(i_i2c_slave_model.adr_b, 8'hA1);
    chk(8'(i_i2c_slave_model.starts), 8'h04);
    cyc(1'b0, i2c_pkg::RX_ADDR, 8'h00);
    chk(rdata, 8'hA5);
    cyc(1'b0, i2c_pkg::CTL_ADDR, 8'h00);
    chk(rdata & 8'h80, 8'h00);
    chk({7'h00, rx_int_req}, 8'h01);
    pulse_ivec();
    chk({7'h00, rx_int_req}, 8'h00);
  endtask : t_read
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_write();
    t_nack();
    t_read();
    wrap_up();
  end
  // Watchdog: all transfers fit well inside this span
  initial begin
    #3000000;
    fails++;
    wrap_up();
  end
endmodule : i2c_master_register_port_tb
`default_nettype wire
